// [bench/remote_tx_model.sv]
// remote serial transmitter: oob bursts, idles and reference clocks
`timescale 1ns/10ps
module remote_tx_model (
   output logic       rx_activity_pin,
   output logic [3:0] ref_clk
);
   logic [1:0] run_sel;
   logic       tick;
   // one reference runs, well below half the fabric clock
   initial begin
      rx_activity_pin = 1'b0;
      run_sel = 2'h0;
      tick = 1'b0;
      forever #80 tick = ~tick;
   end
   // unselected references stand still
   assign ref_clk = tick ? 4'h1 << run_sel : 4'h0;
   // line busy or silent for n reference periods
   task automatic hold_line(input logic busy, input int n);
      repeat (n) @(negedge tick) rx_activity_pin = busy;
   endtask
   // long silence clears any partial count, then bursts with gaps
   task automatic com_seq(input int blen, input int glen, input int nb,
                          input int sc);
      hold_line(1'b0, 80 * sc);
      repeat (nb) begin
         hold_line(1'b1, blen * sc);
         hold_line(1'b0, glen * sc);
      end
   endtask
endmodule

// [bench/rx_oob_com_detector_props.sv]
// assertion checker for the receive oob com detector
`timescale 1ns/10ps
module rx_oob_com_detector_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        rx_activity_pin,
   input wire logic        line_idle_flag,
   input wire logic        init_seq_detect,
   input wire logic        sas_seq_detect,
   input wire logic        wake_seq_detect,
   input wire logic        cdr_freeze,
   input wire logic        cdr_override_enable,
   input wire logic        rx_analog_reset,
   input wire logic        rx_user_ready,
   input wire logic        oob_reserved_reset_in,
   input wire logic        rx_reset_complete
);
   logic [12:0] ctrl_ff, nxt_ctrl;
   logic [5:0]  wait_ff, nxt_wait;
   logic        pwr_off, on_now, det_any, bad_addr;
   // shadow of the control word, cycles since the analog reset dropped
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (psel && penable && pwrite && paddr == oob_pkg::ADDR_CTRL)
         nxt_ctrl = pwdata[12:0];
      nxt_wait = rx_analog_reset ? 6'h00 :
                 wait_ff + {5'h00, wait_ff != 6'h3f};
      // the reserved reset stops the com machine but not the idle flag
      pwr_off = !ctrl_ff[2] || ctrl_ff[12];
      on_now = ctrl_ff[2] && ctrl_ff[1:0] != oob_pkg::IDLE_LOW;
      det_any = init_seq_detect || sas_seq_detect || wake_seq_detect;
      bad_addr = paddr > 8'h18 || paddr[1:0] != 2'h0;
   end
   // shadow registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= oob_pkg::CTRL_RST;
         wait_ff <= 6'h00;
      end else begin
         ctrl_ff <= nxt_ctrl;
         wait_ff <= nxt_wait;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   idle_forced_a: assert property (
      (ctrl_ff[1:0] == oob_pkg::IDLE_LOW) [*3] |-> !line_idle_flag)
      else $error("idle flag not forced low");
   idle_busy_a: assert property (
      (on_now && rx_activity_pin) [*4] |-> !line_idle_flag)
      else $error("idle flag high during activity");
   idle_quiet_a: assert property (
      (on_now && !rx_activity_pin) [*4] |-> line_idle_flag)
      else $error("idle flag low on a quiet line");
   idle_off_a: assert property (
      (!ctrl_ff[2] && ctrl_ff[1:0] != oob_pkg::IDLE_LOW) [*4]
      |-> line_idle_flag)
      else $error("idle flag low while detector off");
   det_off_a: assert property (pwr_off [*4] |-> !det_any)
      else $error("detect while detector off");
   one_kind_a: assert property (
      $onehot0({init_seq_detect, sas_seq_detect, wake_seq_detect}))
      else $error("two detect kinds at once");
   det_pulse_a: assert property (det_any |=> !det_any [*3])
      else $error("detect longer than one pulse");
   ctrl_pins_a: assert property ({oob_reserved_reset_in, rx_user_ready,
      rx_analog_reset, cdr_override_enable, cdr_freeze} == ctrl_ff[12:8])
      else $error("control pins differ from control word");
   rst_clear_a: assert property (rx_analog_reset |=> !rx_reset_complete)
      else $error("reset complete kept during analog reset");
   rst_late_a: assert property (wait_ff == 6'h28 |-> rx_reset_complete)
      else $error("reset complete never rose");
   bus_err_a: assert property (psel && penable |->
      pslverr == bad_addr && (pwrite || !bad_addr || prdata == 32'h0))
      else $error("bad error response");
endmodule
bind rx_oob_com_detector rx_oob_com_detector_props props_i (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .rx_activity_pin(rx_activity_pin),
   .line_idle_flag(line_idle_flag), .init_seq_detect(init_seq_detect),
   .sas_seq_detect(sas_seq_detect), .wake_seq_detect(wake_seq_detect),
   .cdr_freeze(cdr_freeze), .cdr_override_enable(cdr_override_enable),
   .rx_analog_reset(rx_analog_reset), .rx_user_ready(rx_user_ready),
   .oob_reserved_reset_in(oob_reserved_reset_in),
   .rx_reset_complete(rx_reset_complete));

// [bench/rx_oob_com_detector_tb.sv]
// self-checking testbench for the receive oob com detector
`timescale 1ns/10ps
module rx_oob_com_detector_tb;
   typedef struct {
      logic [12:0] ctrl;
      int          src, blen, glen, nb, sc;
      logic [2:0]  exp;
   } case_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        rx_activity_pin, line_idle_flag, rx_reset_complete;
   logic        init_seq_detect, sas_seq_detect, wake_seq_detect;
   logic        cdr_freeze, cdr_override_enable, rx_analog_reset;
   logic        rx_user_ready, oob_reserved_reset_in;
   logic [3:0]  clks;
   logic [7:0]  n_init = 8'h00, n_sas = 8'h00, n_wake = 8'h00;
   logic [23:0] snap;
   int          miscompares = 0, tests_run = 0;
   logic [31:0] defaults [5] = '{32'(oob_pkg::CTRL_RST),
      {26'h0, 3'h4, 3'h4}, {14'h0, 6'h24, 6'h08, 6'h08},
      {14'h0, 6'h07, 6'h15, 6'h04}, {19'h0, 7'h40, 6'h0c}};
   case_t       cases [18] = '{'{13'h004, 0, 8, 5, 4, 1, 3'h1},
      '{13'h004, 0, 8, 10, 4, 1, 3'h4}, '{13'h004, 0, 8, 21, 4, 1, 3'h4},
      '{13'h004, 0, 8, 22, 4, 1, 3'h2}, '{13'h004, 0, 36, 30, 4, 1, 3'h2},
      '{13'h004, 0, 8, 70, 4, 1, 3'h0}, '{13'h004, 0, 7, 5, 4, 1, 3'h0},
      '{13'h004, 0, 9, 5, 4, 1, 3'h0}, '{13'h004, 0, 8, 5, 3, 1, 3'h0},
      '{13'h084, 1, 8, 5, 4, 1, 3'h1}, '{13'h0c4, 2, 8, 5, 4, 1, 3'h1},
      '{13'h024, 3, 8, 5, 4, 1, 3'h1}, '{13'h004, 1, 8, 5, 4, 1, 3'h0},
      '{13'h00c, 0, 8, 5, 4, 2, 3'h1}, '{13'h014, 0, 8, 5, 4, 4, 3'h1},
      '{13'h01c, 0, 8, 5, 4, 8, 3'h1}, '{13'h000, 0, 8, 5, 4, 1, 3'h0},
      '{13'h1004, 0, 8, 5, 4, 1, 3'h0}};
   rx_oob_com_detector dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_activity_pin(rx_activity_pin), .channel_pll_refclk(clks[0]),
      .common_pll_refclk_a(clks[1]), .common_pll_refclk_b(clks[2]),
      .sigvalid_clock(clks[3]), .line_idle_flag(line_idle_flag),
      .init_seq_detect(init_seq_detect), .sas_seq_detect(sas_seq_detect),
      .wake_seq_detect(wake_seq_detect), .cdr_freeze(cdr_freeze),
      .cdr_override_enable(cdr_override_enable),
      .rx_analog_reset(rx_analog_reset), .rx_user_ready(rx_user_ready),
      .oob_reserved_reset_in(oob_reserved_reset_in),
      .rx_reset_complete(rx_reset_complete));
   remote_tx_model partner (.rx_activity_pin(rx_activity_pin),
      .ref_clk(clks));
   // clock and detect pulse counters
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      n_init <= n_init + {7'h00, init_seq_detect === 1'b1};
      n_sas <= n_sas + {7'h00, sas_seq_detect === 1'b1};
      n_wake <= n_wake + {7'h00, wake_seq_detect === 1'b1};
   end
   task automatic test_done();
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle_is(input logic e);
      repeat (4) @(negedge pclk);
      check({31'h0, line_idle_flag}, {31'h0, e});
   endtask
   // run sequences and compare pulse counts per kind
   task automatic seq(input case_t c);
      partner.run_sel = 2'(c.src);
      snap = {n_init, n_sas, n_wake};
      partner.com_seq(c.blen, c.glen, c.nb, c.sc);
      repeat (8) @(negedge pclk);
      check(32'({n_init, n_sas, n_wake} - snap),
            32'({7'h0, c.exp[2], 7'h0, c.exp[1], 7'h0, c.exp[0]}));
   endtask
   initial begin
      repeat (80000) @(posedge pclk);
      miscompares++;
      test_done();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check(rd, defaults[i]);
      end
      apb(1'b0, 8'h1c, 32'h0);
      check({er, rd[30:0]}, 32'h80000000);
      // idle flag follows the line, parks high when off, forced low
      idle_is(1'b1);
      partner.hold_line(1'b1, 2);
      idle_is(1'b0);
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h000);
      idle_is(1'b1);
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h007);
      partner.hold_line(1'b0, 2);
      idle_is(1'b0);
      foreach (cases[i]) begin
         apb(1'b1, oob_pkg::ADDR_CTRL, {19'h0, cases[i].ctrl});
         seq(cases[i]);
      end
      // every kind was seen; the sticky flags clear on a write of ones
      apb(1'b0, oob_pkg::ADDR_EVENT, 32'h0);
      check(rd, 32'h7);
      apb(1'b1, oob_pkg::ADDR_EVENT, 32'h7);
      apb(1'b0, oob_pkg::ADDR_EVENT, 32'h0);
      check(rd, 32'h0);
      // lowered match counts accept two bursts and two idles
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h004);
      apb(1'b1, oob_pkg::ADDR_MATCH, 32'h12);
      seq('{13'h004, 0, 8, 5, 2, 1, 3'h1});
      // control pins, then freeze released before the analog reset
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h1b04);
      repeat (2) @(negedge pclk);
      check({27'h0, oob_reserved_reset_in, rx_user_ready, rx_analog_reset,
             cdr_override_enable, cdr_freeze}, 32'h1b);
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h0804);
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h0c04);
      repeat (2) @(negedge pclk);
      check({27'h0, oob_reserved_reset_in, rx_user_ready, rx_analog_reset,
             cdr_override_enable, cdr_freeze}, 32'h0c);
      check({31'h0, rx_reset_complete}, 32'h0);
      // analog reset released with user ready up; reset complete rises after the count
      apb(1'b1, oob_pkg::ADDR_CTRL, 32'h0804);
      repeat (oob_pkg::DONE_CYCLES + 8) @(negedge pclk);
      check({31'h0, rx_reset_complete}, 32'h1);
      // quiet line, reset complete, machine idle with empty counters
      apb(1'b0, oob_pkg::ADDR_STATUS, 32'h0);
      check(rd, 32'h13);
      test_done();
   end
endmodule

// [hdl/oob_pkg.sv]
// constants, types and register layout of the receive oob com detector
//
// Overview of operation
// - idle select 00 follows detector, 11 forces low
// - idle flag low on activity while oob power is up, high otherwise unless forced low
// - separate init, sas and wake detect flags
// - sysclk select 00 channel, 10 ref a, 11 ref b
// - oob power bit 0 down, 1 up
// - divider codes 11/10/01/00 divide 8/4/2/1
// - clock source 0 sysclk, 1 signal-valid clock
// - burst count for match, default four
// - idle count for match, default four
// - bursts shorter than lower bound rejected
// - bursts longer than upper bound rejected unless they reach the sas burst lower bound
// - separate sas burst lower bound, default 36
// - init gap between 4 and 21 counts
// - sas gap between 12 and 64 counts
// - gaps above wake bound are not wake
// - reset complete rises after analog reset ends
package oob_pkg;
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_MATCH  = 8'h04;
   localparam logic [7:0]  ADDR_BURST  = 8'h08;
   localparam logic [7:0]  ADDR_GAP    = 8'h0c;
   localparam logic [7:0]  ADDR_SASGAP = 8'h10;
   localparam logic [7:0]  ADDR_STATUS = 8'h14;
   localparam logic [7:0]  ADDR_EVENT  = 8'h18;
   localparam logic [12:0] CTRL_RST    = 13'h0004;
   localparam logic [5:0]  MATCH_RST   = 6'h24;
   localparam logic [17:0] BURST_RST   = 18'h24208;
   localparam logic [17:0] GAP_RST     = 18'h07544;
   localparam logic [12:0] SASGAP_RST  = 13'h100c;
   localparam logic [1:0]  IDLE_FOLLOW = 2'h0;
   localparam logic [1:0]  IDLE_LOW    = 2'h3;
   localparam logic [1:0]  SYS_CHANNEL = 2'h0;
   localparam logic [1:0]  SYS_REF_A   = 2'h2;
   localparam logic [1:0]  SYS_REF_B   = 2'h3;
   localparam logic [6:0]  RUN_MAX     = 7'h7f;
   localparam logic [2:0]  CNT_MAX     = 3'h7;
   localparam logic [7:0]  DONE_CYCLES = 8'h20;
   typedef enum logic [1:0] {
      GC_NONE = 2'h0, GC_INIT = 2'h1, GC_SAS = 2'h2, GC_WAKE = 2'h3
   } gap_class_t;
   typedef enum logic [2:0] {
      ST_OFF = 3'h1, ST_IDLE = 3'h2, ST_BURST = 3'h4
   } com_state_t;
   typedef struct packed {
      logic       rsv_reset;
      logic       user_ready;
      logic       analog_reset;
      logic       cdr_override;
      logic       cdr_freeze;
      logic [1:0] sys_sel;
      logic       clk_src;
      logic [1:0] div;
      logic       power;
      logic [1:0] idle_sel;
   } ctrl_t;
   typedef struct packed {
      logic [2:0] idles;
      logic [2:0] bursts;
   } match_t;
   typedef struct packed {
      logic [5:0] sas_lo;
      logic [5:0] hi;
      logic [5:0] lo;
   } burst_t;
   typedef struct packed {
      logic [5:0] wake_hi;
      logic [5:0] init_hi;
      logic [5:0] init_lo;
   } gap_t;
   typedef struct packed {
      logic [6:0] hi;
      logic [5:0] lo;
   } sas_gap_t;
endpackage

// [hdl/rx_oob_com_detector.sv]
// receive oob idle indication, com sequence detector and apb registers
`timescale 1ns/10ps
module rx_oob_com_detector (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_activity_pin,
   input  wire logic        channel_pll_refclk,
   input  wire logic        common_pll_refclk_a,
   input  wire logic        common_pll_refclk_b,
   input  wire logic        sigvalid_clock,
   output logic             line_idle_flag,
   output logic             init_seq_detect,
   output logic             sas_seq_detect,
   output logic             wake_seq_detect,
   output logic             cdr_freeze,
   output logic             cdr_override_enable,
   output logic             rx_analog_reset,
   output logic             rx_user_ready,
   output logic             oob_reserved_reset_in,
   output logic             rx_reset_complete
);
   oob_pkg::ctrl_t      ctrl_ff, nxt_ctrl;
   oob_pkg::match_t     match_ff, nxt_match;
   oob_pkg::burst_t     burst_ff, nxt_burst;
   oob_pkg::gap_t       gap_ff, nxt_gap;
   oob_pkg::sas_gap_t   sgap_ff, nxt_sgap;
   oob_pkg::com_state_t state_ff, nxt_state;
   oob_pkg::gap_class_t cls_ff, nxt_cls, gcls;
   logic [2:0]  evt_ff, nxt_evt;
   logic [31:0] prdata_ff, nxt_prdata, rdata;
   logic [4:0]  s1_ff, s2_ff, s3_ff, nxt_s1, nxt_s2, nxt_s3, rise;
   logic [2:0]  div_ff, nxt_div, mask;
   logic [6:0]  run_ff, nxt_run, cls_lo;
   logic [2:0]  bcnt_ff, nxt_bcnt, icnt_ff, nxt_icnt;
   logic [2:0]  det_ff, nxt_det;
   logic [7:0]  done_cnt_ff, nxt_done_cnt;
   logic        done_ff, nxt_done, idle_ff, nxt_idle;
   logic        sys_tick, src_tick, oob_tick, act, mapped;
   logic        fit_init, fit_sas, fit_wake, own_fit, burst_ok;
   logic        wr_en, rd_setup;

   // two flip-flop synchronisers, third stage for edge detection
   always_comb begin
      nxt_s1 = {sigvalid_clock, common_pll_refclk_b,
                common_pll_refclk_a, channel_pll_refclk, rx_activity_pin};
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 5'h00;
         s2_ff <= 5'h00;
         s3_ff <= 5'h00;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         s3_ff <= nxt_s3;
      end
   end
   assign rise = s2_ff & ~s3_ff;
   assign act  = s2_ff[0] & ctrl_ff.power;

   // oob clock source selection and divider, gives a one-cycle tick
   always_comb begin
      case (ctrl_ff.sys_sel)
         oob_pkg::SYS_REF_A: sys_tick = rise[2];
         oob_pkg::SYS_REF_B: sys_tick = rise[3];
         default:            sys_tick = rise[1];
      endcase
      src_tick = ctrl_ff.clk_src ? rise[4] : sys_tick;
      case (ctrl_ff.div)
         2'h3:    mask = 3'h7;
         2'h2:    mask = 3'h3;
         2'h1:    mask = 3'h1;
         default: mask = 3'h0;
      endcase
      nxt_div  = src_tick ? div_ff + 3'h1 : div_ff;
      oob_tick = src_tick && ((div_ff & mask) == mask);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 3'h0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   // burst and gap classification against the programmed bounds
   always_comb begin
      fit_init = (run_ff >= {1'b0, gap_ff.init_lo})
              && (run_ff <= {1'b0, gap_ff.init_hi});
      fit_sas  = (run_ff >= {1'b0, sgap_ff.lo})
              && (run_ff <= sgap_ff.hi);
      fit_wake = (run_ff != 7'h00)
              && (run_ff <= {1'b0, gap_ff.wake_hi});
      burst_ok = ((run_ff >= {1'b0, burst_ff.lo})
              && (run_ff <= {1'b0, burst_ff.hi}))
              || (run_ff >= {1'b0, burst_ff.sas_lo});
      own_fit  = ((cls_ff == oob_pkg::GC_INIT) && fit_init)
              || ((cls_ff == oob_pkg::GC_SAS) && fit_sas)
              || ((cls_ff == oob_pkg::GC_WAKE) && fit_wake);
      gcls = oob_pkg::GC_NONE;
      if (fit_sas) begin
         gcls = oob_pkg::GC_SAS;
      end
      if (fit_init) begin
         gcls = oob_pkg::GC_INIT;
      end
      if (fit_wake) begin
         gcls = oob_pkg::GC_WAKE;
      end
      if (own_fit) begin
         gcls = cls_ff;
      end
      case (cls_ff)
         oob_pkg::GC_INIT: cls_lo = {1'b0, gap_ff.init_lo};
         oob_pkg::GC_SAS:  cls_lo = {1'b0, sgap_ff.lo};
         oob_pkg::GC_WAKE: cls_lo = 7'h01;
         default:          cls_lo = oob_pkg::RUN_MAX;
      endcase
   end

   // com state machine, advances once per oob tick
   always_comb begin
      nxt_state = state_ff;
      nxt_run   = run_ff;
      nxt_bcnt  = bcnt_ff;
      nxt_icnt  = icnt_ff;
      nxt_cls   = cls_ff;
      nxt_det   = 3'h0;
      if (!ctrl_ff.power || ctrl_ff.rsv_reset) begin
         nxt_state = oob_pkg::ST_OFF;
         nxt_run   = 7'h00;
         nxt_bcnt  = 3'h0;
         nxt_icnt  = 3'h0;
         nxt_cls   = oob_pkg::GC_NONE;
      end else if (oob_tick) begin
         case (state_ff)
            oob_pkg::ST_OFF: begin
               nxt_state = oob_pkg::ST_IDLE;
               nxt_run   = 7'h00;
            end
            oob_pkg::ST_IDLE: begin
               if (act) begin
                  nxt_state = oob_pkg::ST_BURST;
                  nxt_run   = 7'h01;
                  if (bcnt_ff == 3'h0) begin
                     nxt_cls = oob_pkg::GC_NONE;
                  end else if (gcls == oob_pkg::GC_NONE) begin
                     nxt_bcnt = 3'h0;
                     nxt_icnt = 3'h0;
                     nxt_cls  = oob_pkg::GC_NONE;
                  end else if (cls_ff != oob_pkg::GC_NONE
                               && gcls != cls_ff) begin
                     nxt_bcnt = 3'h1;
                     nxt_icnt = 3'h1;
                     nxt_cls  = gcls;
                  end else begin
                     nxt_cls  = gcls;
                     if (icnt_ff != oob_pkg::CNT_MAX) begin
                        nxt_icnt = icnt_ff + 3'h1;
                     end
                  end
               end else begin
                  if (run_ff != oob_pkg::RUN_MAX) begin
                     nxt_run = run_ff + 7'h01;
                  end
                  // trailing gap closes the sequence once it reaches its
                  // lower bound; the first idle tick is spent leaving burst
                  if (cls_ff != oob_pkg::GC_NONE
                      && bcnt_ff >= match_ff.bursts
                      && ({1'b0, icnt_ff} + 4'h1)
                         >= {1'b0, match_ff.idles}
                      && (run_ff + 7'h01) >= cls_lo) begin
                     case (cls_ff)
                        oob_pkg::GC_INIT: nxt_det = 3'h1;
                        oob_pkg::GC_SAS:  nxt_det = 3'h2;
                        default:          nxt_det = 3'h4;
                     endcase
                     nxt_bcnt = 3'h0;
                     nxt_icnt = 3'h0;
                     nxt_cls  = oob_pkg::GC_NONE;
                  end
               end
            end
            oob_pkg::ST_BURST: begin
               if (act) begin
                  if (run_ff != oob_pkg::RUN_MAX) begin
                     nxt_run = run_ff + 7'h01;
                  end
               end else begin
                  nxt_state = oob_pkg::ST_IDLE;
                  nxt_run   = 7'h01;
                  if (burst_ok) begin
                     if (bcnt_ff != oob_pkg::CNT_MAX) begin
                        nxt_bcnt = bcnt_ff + 3'h1;
                     end
                  end else begin
                     nxt_bcnt = 3'h0;
                     nxt_icnt = 3'h0;
                     nxt_cls  = oob_pkg::GC_NONE;
                  end
               end
            end
            default: begin
               nxt_state = oob_pkg::ST_OFF;
            end
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= oob_pkg::ST_OFF;
         run_ff   <= 7'h00;
         bcnt_ff  <= 3'h0;
         icnt_ff  <= 3'h0;
         cls_ff   <= oob_pkg::GC_NONE;
         det_ff   <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         run_ff   <= nxt_run;
         bcnt_ff  <= nxt_bcnt;
         icnt_ff  <= nxt_icnt;
         cls_ff   <= nxt_cls;
         det_ff   <= nxt_det;
      end
   end

   // idle indication and reset-complete counter
   always_comb begin
      nxt_idle = (ctrl_ff.idle_sel == oob_pkg::IDLE_LOW) ? 1'b0
               : ~act;
      nxt_done     = done_ff;
      nxt_done_cnt = done_cnt_ff;
      if (ctrl_ff.analog_reset) begin
         nxt_done     = 1'b0;
         nxt_done_cnt = 8'h00;
      end else if (!done_ff) begin
         if (done_cnt_ff == oob_pkg::DONE_CYCLES - 8'h01) begin
            nxt_done = 1'b1;
         end else begin
            nxt_done_cnt = done_cnt_ff + 8'h01;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_ff     <= 1'b1;
         done_ff     <= 1'b0;
         done_cnt_ff <= 8'h00;
      end else begin
         idle_ff     <= nxt_idle;
         done_ff     <= nxt_done;
         done_cnt_ff <= nxt_done_cnt;
      end
   end

   // apb slave: writes in access phase, read data latched in setup
   always_comb begin
      wr_en    = psel && penable && pwrite;
      rd_setup = psel && !penable;
      mapped   = (paddr == oob_pkg::ADDR_CTRL)
              || (paddr == oob_pkg::ADDR_MATCH)
              || (paddr == oob_pkg::ADDR_BURST)
              || (paddr == oob_pkg::ADDR_GAP)
              || (paddr == oob_pkg::ADDR_SASGAP)
              || (paddr == oob_pkg::ADDR_STATUS)
              || (paddr == oob_pkg::ADDR_EVENT);
      case (paddr)
         oob_pkg::ADDR_CTRL:   rdata = {19'h0, ctrl_ff};
         oob_pkg::ADDR_MATCH:  rdata = {26'h0, match_ff};
         oob_pkg::ADDR_BURST:  rdata = {14'h0, burst_ff};
         oob_pkg::ADDR_GAP:    rdata = {14'h0, gap_ff};
         oob_pkg::ADDR_SASGAP: rdata = {19'h0, sgap_ff};
         oob_pkg::ADDR_STATUS: rdata = {17'h0, icnt_ff, 1'b0, bcnt_ff,
                                        2'h0, state_ff, act, done_ff,
                                        idle_ff};
         oob_pkg::ADDR_EVENT:  rdata = {29'h0, evt_ff};
         default:              rdata = 32'h0;
      endcase
      nxt_prdata = rd_setup ? rdata : prdata_ff;
      nxt_ctrl   = ctrl_ff;
      nxt_match  = match_ff;
      nxt_burst  = burst_ff;
      nxt_gap    = gap_ff;
      nxt_sgap   = sgap_ff;
      nxt_evt    = evt_ff;
      if (wr_en) begin
         case (paddr)
            oob_pkg::ADDR_CTRL:   nxt_ctrl  = pwdata[12:0];
            oob_pkg::ADDR_MATCH:  nxt_match = pwdata[5:0];
            oob_pkg::ADDR_BURST:  nxt_burst = pwdata[17:0];
            oob_pkg::ADDR_GAP:    nxt_gap   = pwdata[17:0];
            oob_pkg::ADDR_SASGAP: nxt_sgap  = pwdata[12:0];
            oob_pkg::ADDR_EVENT:  nxt_evt   = evt_ff & ~pwdata[2:0];
            default:              nxt_evt   = evt_ff;
         endcase
      end
      nxt_evt = nxt_evt | det_ff; // set wins over clear
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff   <= oob_pkg::CTRL_RST;
         match_ff  <= oob_pkg::MATCH_RST;
         burst_ff  <= oob_pkg::BURST_RST;
         gap_ff    <= oob_pkg::GAP_RST;
         sgap_ff   <= oob_pkg::SASGAP_RST;
         evt_ff    <= 3'h0;
         prdata_ff <= 32'h0;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         match_ff  <= nxt_match;
         burst_ff  <= nxt_burst;
         gap_ff    <= nxt_gap;
         sgap_ff   <= nxt_sgap;
         evt_ff    <= nxt_evt;
         prdata_ff <= nxt_prdata;
      end
   end

   // outputs
   assign prdata                = prdata_ff;
   assign pready                = 1'b1;
   assign pslverr               = psel && penable && !mapped;
   assign line_idle_flag        = idle_ff;
   assign init_seq_detect       = det_ff[0];
   assign sas_seq_detect        = det_ff[1];
   assign wake_seq_detect       = det_ff[2];
   assign cdr_freeze            = ctrl_ff.cdr_freeze;
   assign cdr_override_enable   = ctrl_ff.cdr_override;
   assign rx_analog_reset       = ctrl_ff.analog_reset;
   assign rx_user_ready         = ctrl_ff.user_ready;
   assign oob_reserved_reset_in = ctrl_ff.rsv_reset;
   assign rx_reset_complete     = done_ff;
endmodule
